// ==== mrpt_pkg.sv ====
`default_nettype none
package mrpt_pkg;
	// Word and pattern layout of the paired 8-bit measurement memories.
	localparam int WORD_W = 16;
	localparam int NUM_SETS = 7;
	localparam int SET_W = 3;
	localparam int ADDR_W = 12;
	localparam logic [WORD_W-1:0] PAT_FILL = 16'hAAAA;
	localparam logic [WORD_W-1:0] PAT_ALT = 16'h5555;
	localparam logic [WORD_W-1:0] PAT_MARK = 16'h8888;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
	// Set order: three counter chains, stage A then B, then the interpolator.
	localparam logic [SET_W-1:0] SET_EVENT1_STAGE_A = 3'h0;
	localparam logic [SET_W-1:0] SET_EVENT1_STAGE_B = 3'h1;
	localparam logic [SET_W-1:0] SET_EVENT2_STAGE_A = 3'h2;
	localparam logic [SET_W-1:0] SET_EVENT2_STAGE_B = 3'h3;
	localparam logic [SET_W-1:0] SET_TIMING_STAGE_A = 3'h4;
	localparam logic [SET_W-1:0] SET_TIMING_STAGE_B = 3'h5;
	localparam logic [SET_W-1:0] SET_INTERP = 3'h6;
	localparam logic [SET_W-1:0] SET_LAST = SET_INTERP;

	// Strobes shared by all measurement memories.
	typedef struct packed {
		logic [NUM_SETS-1:0] sel;
		logic wr_en;
		logic meas_mem_read_enable_n;
	} mrpt_mem_ctl_t;

	// First mismatch seen during a run.
	typedef struct packed {
		logic valid;
		logic [SET_W-1:0] set;
		logic [WORD_W-1:0] wr_word;
		logic [WORD_W-1:0] rd_word;
	} mrpt_fail_rpt_t;
endpackage
`default_nettype wire

// ==== mrpt_engine.sv ====
`default_nettype none
// Operation
// RULE1 - Fill every location of the set under test with AAAA first.
// RULE2 - Read location back; anything but AAAA fails and ends the set.
// RULE3 - After good AAAA read, write 5555 to the same location.
// RULE4 - Read again; anything but 5555 fails and ends the set.
// RULE5 - After good 5555 read, write 8888 so aliased locations show it.
// RULE6 - Apply the read-write sequence to every location in turn.
// RULE7 - Two 8-bit memories form one 16-bit word.
// RULE8 - Both memories of a pair are accessed together, never singly.
// RULE9 - Start with event counter one stage A, then the remaining pairs.
// RULE10 - At the end report a fail bit for each of seven sets.
// RULE11 - On mismatch capture address, word written and word read.
// RULE12 - Addresses come from the shared address counter, loaded and stepped.
// RULE13 - Assert the active-low read enable of all memories on reads.
// RULE14 - Stored measurement data is always overwritten by the test.
// RULE15 - Start pulse begins; busy while running; done with pass flag.
module mrpt_engine #(
	parameter int ADDR_W = mrpt_pkg::ADDR_W
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Control.
	input wire logic start,
	output logic busy,
	output logic done,
	output logic pass,
	// Memory side.
	output logic [ADDR_W-1:0] mem_addr,
	output logic [mrpt_pkg::WORD_W-1:0] mem_wr_data,
	output mrpt_pkg::mrpt_mem_ctl_t mem_ctl,
	input wire logic [mrpt_pkg::WORD_W-1:0] mem_rd_data,
	// Report.
	output logic [mrpt_pkg::NUM_SETS-1:0] fail_sets,
	output logic [ADDR_W-1:0] fail_addr,
	output mrpt_pkg::mrpt_fail_rpt_t fail_rpt
);

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_FILL,
		ST_RD_A,
		ST_CMP_A,
		ST_WR_ALT,
		ST_RD_ALT,
		ST_CMP_ALT,
		ST_WR_MARK,
		ST_NEXT_SET,
		ST_DONE
	} mrpt_state_t;

	localparam logic [ADDR_W-1:0] ADDR_FIRST = '0;
	localparam logic [ADDR_W-1:0] ADDR_LAST = '1;

	function automatic logic [mrpt_pkg::NUM_SETS-1:0] set_onehot(
		input logic [mrpt_pkg::SET_W-1:0] s);
		logic [mrpt_pkg::NUM_SETS-1:0] v;
		v = '0;
		v[s] = 1'b1;
		return v;
	endfunction

	function automatic logic [ADDR_W-1:0] addr_step(input logic [ADDR_W-1:0] a);
		return ADDR_W'(a + 1'b1);
	endfunction

	mrpt_state_t state, next_state;
	logic [mrpt_pkg::SET_W-1:0] set_idx, next_set_idx;
	logic [ADDR_W-1:0] next_mem_addr, next_fail_addr;
	logic [mrpt_pkg::WORD_W-1:0] next_mem_wr_data, rd_word, next_rd_word;
	logic [mrpt_pkg::NUM_SETS-1:0] next_fail_sets;
	mrpt_pkg::mrpt_fail_rpt_t next_fail_rpt;
	logic next_done, next_pass;
	logic rd_phase, wr_phase, mismatch;

	// One access drives both memories of the selected pair as one word.
	assign rd_phase = (state == ST_RD_A) || (state == ST_RD_ALT);
	assign wr_phase = (state == ST_FILL) || (state == ST_WR_ALT) || (state == ST_WR_MARK);
	assign mem_ctl.sel = (rd_phase || wr_phase) ? set_onehot(set_idx) : '0; // see RULE7 RULE8
	assign mem_ctl.wr_en = wr_phase; // see RULE14
	assign mem_ctl.meas_mem_read_enable_n = !rd_phase; // see RULE13
	assign busy = (state != ST_IDLE) && (state != ST_DONE); // see RULE15
	assign mismatch = (state == ST_CMP_A) ? (rd_word != mrpt_pkg::PAT_FILL)
		: (rd_word != mrpt_pkg::PAT_ALT);

	always_comb begin
		next_state = state;
		next_set_idx = set_idx;
		next_mem_addr = mem_addr;
		next_mem_wr_data = mem_wr_data;
		next_rd_word = rd_word;
		next_fail_sets = fail_sets;
		next_fail_addr = fail_addr;
		next_fail_rpt = fail_rpt;
		next_done = done;
		next_pass = pass;
		case (state)
			ST_IDLE, ST_DONE: begin
				if (start) begin
					next_state = ST_FILL;
					next_set_idx = mrpt_pkg::SET_EVENT1_STAGE_A; // see RULE9
					next_mem_addr = ADDR_FIRST; // see RULE12
					next_mem_wr_data = mrpt_pkg::PAT_FILL;
					next_fail_sets = '0;
					next_fail_addr = ADDR_FIRST;
					next_fail_rpt = '0;
					next_done = 1'b0;
					next_pass = 1'b0;
				end
			end
			ST_FILL: begin
				// Sweep the whole set with the fill word before any check.
				if (mem_addr == ADDR_LAST) begin // see RULE1
					next_state = ST_RD_A;
					next_mem_addr = ADDR_FIRST; // see RULE12
				end else begin
					next_mem_addr = addr_step(mem_addr);
				end
			end
			ST_RD_A, ST_RD_ALT: begin
				next_rd_word = mem_rd_data;
				next_state = (state == ST_RD_A) ? ST_CMP_A : ST_CMP_ALT;
			end
			ST_CMP_A, ST_CMP_ALT: begin
				if (mismatch) begin // see RULE2 RULE4
					next_state = ST_NEXT_SET;
					next_fail_sets[set_idx] = 1'b1; // see RULE10
					if (!fail_rpt.valid) begin // see RULE11
						next_fail_addr = mem_addr;
						next_fail_rpt.valid = 1'b1;
						next_fail_rpt.set = set_idx;
						next_fail_rpt.wr_word = (state == ST_CMP_A)
							? mrpt_pkg::PAT_FILL : mrpt_pkg::PAT_ALT;
						next_fail_rpt.rd_word = rd_word;
					end
				end else if (state == ST_CMP_A) begin
					next_state = ST_WR_ALT;
					next_mem_wr_data = mrpt_pkg::PAT_ALT; // see RULE3
				end else begin
					next_state = ST_WR_MARK;
					next_mem_wr_data = mrpt_pkg::PAT_MARK; // see RULE5
				end
			end
			ST_WR_ALT: begin
				next_state = ST_RD_ALT;
			end
			ST_WR_MARK: begin
				next_mem_wr_data = mrpt_pkg::PAT_FILL;
				if (mem_addr == ADDR_LAST) begin // see RULE6
					next_state = ST_NEXT_SET;
				end else begin
					next_state = ST_RD_A;
					next_mem_addr = addr_step(mem_addr); // see RULE12
				end
			end
			ST_NEXT_SET: begin
				if (set_idx == mrpt_pkg::SET_LAST) begin
					next_state = ST_DONE;
					next_done = 1'b1; // see RULE15
					next_pass = (fail_sets == '0);
				end else begin
					next_state = ST_FILL;
					next_set_idx = mrpt_pkg::SET_W'(set_idx + 1'b1); // see RULE9
					next_mem_addr = ADDR_FIRST;
					next_mem_wr_data = mrpt_pkg::PAT_FILL;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			set_idx <= mrpt_pkg::SET_EVENT1_STAGE_A;
			mem_addr <= ADDR_FIRST;
			mem_wr_data <= mrpt_pkg::WORD_ZERO;
			rd_word <= mrpt_pkg::WORD_ZERO;
			fail_sets <= '0;
			fail_addr <= ADDR_FIRST;
			fail_rpt <= '0;
			done <= 1'b0;
			pass <= 1'b0;
		end else begin
			state <= next_state;
			set_idx <= next_set_idx;
			mem_addr <= next_mem_addr;
			mem_wr_data <= next_mem_wr_data;
			rd_word <= next_rd_word;
			fail_sets <= next_fail_sets;
			fail_addr <= next_fail_addr;
			fail_rpt <= next_fail_rpt;
			done <= next_done;
			pass <= next_pass;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_good_alt;
		state == ST_CMP_ALT && rd_word == mrpt_pkg::PAT_ALT;
	endsequence
	sequence s_mark_write;
		mem_ctl.wr_en && mem_wr_data == mrpt_pkg::PAT_MARK;
	endsequence

	property p_fill_word;
		state == ST_FILL |-> mem_ctl.wr_en && mem_wr_data == mrpt_pkg::PAT_FILL;
	endproperty
	a_fill_word: assert property (p_fill_word) else $error("fill word wrong"); // see RULE1

	property p_fail_fill;
		state == ST_CMP_A && rd_word != mrpt_pkg::PAT_FILL
			|=> state == ST_NEXT_SET && fail_sets[set_idx];
	endproperty
	a_fail_fill: assert property (p_fail_fill) else $error("fill mismatch missed"); // see RULE2

	property p_alt_after_fill;
		state == ST_CMP_A && rd_word == mrpt_pkg::PAT_FILL
			|=> mem_ctl.wr_en && mem_wr_data == mrpt_pkg::PAT_ALT && $stable(mem_addr);
	endproperty
	a_alt_after_fill: assert property (p_alt_after_fill) else $error("no alt write"); // see RULE3

	property p_fail_alt;
		state == ST_CMP_ALT && rd_word != mrpt_pkg::PAT_ALT
			|=> state == ST_NEXT_SET && fail_sets[set_idx];
	endproperty
	a_fail_alt: assert property (p_fail_alt) else $error("alt mismatch missed"); // see RULE4

	property p_mark_after_alt;
		s_good_alt |=> s_mark_write ##0 $stable(mem_addr);
	endproperty
	a_mark_after_alt: assert property (p_mark_after_alt) else $error("no mark write"); // see RULE5

	property p_addr_walk;
		state == ST_WR_MARK && mem_addr != ADDR_LAST
			|=> state == ST_RD_A && mem_addr == addr_step($past(mem_addr));
	endproperty
	a_addr_walk: assert property (p_addr_walk) else $error("address not stepped"); // see RULE6

	property p_pair_select;
		(mem_ctl.wr_en || !mem_ctl.meas_mem_read_enable_n) |-> $onehot(mem_ctl.sel);
	endproperty
	a_pair_select: assert property (p_pair_select) else $error("pair not selected"); // see RULE8

	property p_first_set;
		state == ST_IDLE && start |=> state == ST_FILL && mem_ctl.sel[0] && mem_addr == '0;
	endproperty
	a_first_set: assert property (p_first_set) else $error("wrong first set"); // see RULE9

	property p_report;
		state == ST_NEXT_SET && set_idx == mrpt_pkg::SET_LAST
			|=> done && pass == (fail_sets == '0) && !busy;
	endproperty
	a_report: assert property (p_report) else $error("final report wrong"); // see RULE10

	property p_capture;
		state == ST_CMP_ALT && rd_word != mrpt_pkg::PAT_ALT && !fail_rpt.valid
			|=> fail_rpt.valid && fail_rpt.rd_word == $past(rd_word)
				&& fail_addr == $past(mem_addr);
	endproperty
	a_capture: assert property (p_capture) else $error("failure not captured"); // see RULE11

	property p_read_enable;
		state == ST_RD_A |-> !mem_ctl.meas_mem_read_enable_n ##1 mem_ctl.meas_mem_read_enable_n;
	endproperty
	a_read_enable: assert property (p_read_enable) else $error("read enable wrong"); // see RULE13

	property p_busy;
		state == ST_IDLE && start |=> busy && !done;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not raised"); // see RULE15

	property p_fill_sweep;
		state == ST_FILL && mem_addr != ADDR_LAST
			|=> state == ST_FILL && mem_addr == addr_step($past(mem_addr));
	endproperty
	a_fill_sweep: assert property (p_fill_sweep) else $error("fill did not step"); // see RULE12

	property p_fill_end;
		state == ST_FILL && mem_addr == ADDR_LAST
			|=> state == ST_RD_A && mem_addr == ADDR_FIRST;
	endproperty
	a_fill_end: assert property (p_fill_end) else $error("no check after fill"); // see RULE1

	property p_word_capture;
		rd_phase |=> rd_word == $past(mem_rd_data);
	endproperty
	a_word_capture: assert property (p_word_capture) else $error("read word lost"); // see RULE7

	property p_set_advance;
		state == ST_NEXT_SET && set_idx != mrpt_pkg::SET_LAST
			|=> state == ST_FILL && set_idx == $past(set_idx) + 1'b1
				&& mem_addr == ADDR_FIRST;
	endproperty
	a_set_advance: assert property (p_set_advance) else $error("set order wrong"); // see RULE9

	property p_restart;
		state == ST_DONE && start |=> state == ST_FILL && fail_sets == '0 && !fail_rpt.valid;
	endproperty
	a_restart: assert property (p_restart) else $error("restart not clean"); // see RULE15

endmodule // mrpt_engine
`default_nettype wire

// ==== mrpt_mem_model.sv ====
`default_nettype none
module mrpt_mem_model #(
	parameter int ADDR_W = 3
) (
	// Clock.
	input wire logic clk,
	// Memory side.
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic [15:0] mem_wr_data,
	input wire mrpt_pkg::mrpt_mem_ctl_t mem_ctl,
	output logic [15:0] mem_rd_data,
	// Fault injection; a set index of 7 disables it.
	input wire logic [2:0] flt_set,
	input wire logic [ADDR_W-1:0] flt_addr,
	input wire logic [15:0] flt_pat,
	input wire logic [15:0] flt_mask,
	input wire logic [2:0] alias_set
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [7][2**ADDR_W];
	logic [15:0] last = 16'h0000;
	logic [15:0] val;
	logic [2:0] s;
	logic [ADDR_W-1:0] ea;
	always_comb begin
		s = 3'h0;
		for (int i = 0; i < 7; i++) if (mem_ctl.sel[i]) s = 3'(i);
		ea = mem_addr;
		if (s == alias_set) ea[ADDR_W-1] = 1'b0;
		val = mem[s][ea];
		if (s == flt_set && ea == flt_addr && val == flt_pat) val = val ^ flt_mask;
		// An undriven bus shows the inverse of the last word, never a stale copy.
		if (!mem_ctl.meas_mem_read_enable_n && mem_ctl.sel != 7'h00) mem_rd_data = val;
		else mem_rd_data = ~last;
	end
	always_ff @(posedge clk) begin
		if (!mem_ctl.meas_mem_read_enable_n) last <= mem_rd_data;
		// Both bytes of a pair take the word together.
		for (int i = 0; i < 7; i++) if (mem_ctl.wr_en && mem_ctl.sel[i]) mem[i][ea] <= mem_wr_data;
	end
endmodule // mrpt_mem_model
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AW = 3;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic start = 1'b0;
	logic busy, done, pass;
	logic [AW-1:0] mem_addr, fail_addr, flt_addr;
	logic [15:0] mem_wr_data, mem_rd_data, flt_pat, flt_mask;
	mrpt_pkg::mrpt_mem_ctl_t mem_ctl;
	mrpt_pkg::mrpt_fail_rpt_t fail_rpt;
	logic [6:0] fail_sets;
	logic [2:0] flt_set = 3'h7;
	logic [2:0] alias_set = 3'h7;
	int seed = 32'h5a9c;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	int m [7][8];
	always #5 clk = ~clk;
	mrpt_engine #(.ADDR_W(AW)) dut (.clk(clk), .rst_b(rst_b), .start(start), .busy(busy),
		.done(done), .pass(pass), .mem_addr(mem_addr), .mem_wr_data(mem_wr_data),
		.mem_ctl(mem_ctl), .mem_rd_data(mem_rd_data), .fail_sets(fail_sets),
		.fail_addr(fail_addr), .fail_rpt(fail_rpt));
	mrpt_mem_model #(.ADDR_W(AW)) u_mem (.clk(clk), .mem_addr(mem_addr),
		.mem_wr_data(mem_wr_data), .mem_ctl(mem_ctl), .mem_rd_data(mem_rd_data),
		.flt_set(flt_set), .flt_addr(flt_addr), .flt_pat(flt_pat), .flt_mask(flt_mask),
		.alias_set(alias_set));
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic run(input int t, input logic [2:0] fs, input logic [15:0] fp,
		input logic [2:0] as);
		logic [6:0] efs;
		logic [39:0] erpt;
		logic efv;
		int ea, rd, p, bad, n;
		flt_set = fs;
		flt_pat = fp;
		flt_addr = AW'($random(seed));
		flt_mask = 16'($random(seed)) | 16'h0001;
		alias_set = as;
		efs = 7'h00;
		efv = 1'b0;
		erpt = '0;
		for (int s = 0; s < 7; s++) begin
			for (int a = 0; a < 8; a++) m[s][a] = 16'hAAAA;
			bad = 0;
			for (int a = 0; a < 8 && bad == 0; a++) begin
				ea = (s == as) ? (a & 3) : a;
				for (int k = 0; k < 2 && bad == 0; k++) begin
					p = k ? 16'h5555 : 16'hAAAA;
					rd = m[s][ea];
					if (s == fs && ea == flt_addr && rd == fp) rd = rd ^ flt_mask;
					if (rd != p) begin
						bad = 1;
						efs[s] = 1'b1;
						if (!efv) erpt = {AW'(a), 3'(s), 16'(p), 16'(rd)};
						efv = 1'b1;
					end else m[s][ea] = k ? 16'h8888 : 16'h5555;
				end
			end
		end
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		chk(busy, 1);
		chk({mem_ctl.wr_en, mem_ctl.sel, mem_addr, mem_wr_data}, {8'h81, 3'h0, 16'hAAAA});
		n = 0;
		while (done !== 1'b1 && n < 1000) begin
			// A start while busy must be ignored.
			start = (n == 30);
			if (mem_ctl.meas_mem_read_enable_n === 1'b0) chk(mem_ctl.sel != 7'h00, 1);
			chk($onehot0(mem_ctl.sel), 1);
			@(negedge clk);
			n++;
		end
		start = 1'b0;
		chk({busy, done, pass}, {2'b01, efs == 7'h00});
		chk(fail_sets, efs);
		chk(fail_rpt.valid, efv);
		if (efv) chk({fail_addr, fail_rpt.set, fail_rpt.wr_word, fail_rpt.rd_word}, erpt);
		for (int s = 0; s < 7; s++)
			for (int a = 0; a < 8; a++) if (s != as) chk(u_mem.mem[s][a], m[s][a]);
		$display("test %0d done", t);
		// Let an edge pass so the next start is not set in the step that cleared it.
		@(negedge clk);
	endtask
	initial begin
		flt_addr = '0;
		flt_pat = '0;
		flt_mask = '0;
		repeat (10) @(negedge clk);
		chk({busy, done, mem_ctl.wr_en, mem_ctl.meas_mem_read_enable_n}, 4'b0001);
		rst_b = 1'b1;
		run(1, 3'h7, 16'hAAAA, 3'h7);
		run(2, 3'h2, 16'hAAAA, 3'h7);
		run(3, 3'h0, 16'h5555, 3'h5);
		run(4, 3'h6, 16'hAAAA, 3'h7);
		// Reset in the middle of a run must return the engine to idle.
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		repeat (20) @(negedge clk);
		rst_b = 1'b0;
		@(negedge clk);
		chk({busy, done, pass, mem_ctl.wr_en, mem_ctl.meas_mem_read_enable_n}, 5'h01);
		rst_b = 1'b1;
		run(5, 3'h7, 16'hAAAA, 3'h7);
		complete_run();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			complete_run();
		end
	end
endmodule // tb_top
`default_nettype wire
